// ==== vicd_pkg.sv ====
// Constants for the video input upper_bits_reg_a and decimation register bank.
// Assumes byte-addressed 12-bit register offsets with data on lane 0.
package vicd_pkg;

  // Register byte offsets
  localparam logic [11:0] VICD_OFF_IFMT = 12'h004;
  localparam logic [11:0] VICD_OFF_TEMPORAL_DECIMATION_CTRL = 12'h008;
  localparam logic [11:0] VICD_OFF_EVEN_UPPER_BITS_REG_A_UPPER_BITS = 12'h00c;
  localparam logic [11:0] VICD_OFF_E_VDL = 12'h010;
  localparam logic [11:0] VICD_OFF_E_VAL = 12'h014;
  localparam logic [11:0] VICD_OFF_E_HDL = 12'h018;
  localparam logic [11:0] VICD_OFF_ODD_UPPER_BITS_REG_A_UPPER_BITS = 12'h08c;
  localparam logic [11:0] VICD_OFF_O_VDL = 12'h090;
  localparam logic [11:0] VICD_OFF_O_VAL = 12'h094;
  localparam logic [11:0] VICD_OFF_O_HDL = 12'h098;

  // Reset values
  localparam logic [7:0] VICD_RST_IFMT = 8'h58;
  localparam logic [7:0] VICD_RST_TEMPORAL_DECIMATION_CTRL = 8'h00;
  localparam logic [7:0] VICD_RST_UPPER_BITS_REG_A = 8'h12;
  localparam logic [7:0] VICD_RST_VDL = 8'h16;
  localparam logic [7:0] VICD_RST_VAL = 8'he0;
  localparam logic [7:0] VICD_RST_HDL = 8'h78;

  // Input format fields
  localparam int VICD_IF_SRC_LSB = 5;
  localparam int VICD_IF_XT_LSB = 3;
  localparam int VICD_IF_STD_LSB = 0;

  // Temporal decimation fields
  localparam int VICD_TD_UNIT_BIT = 7;
  localparam int VICD_TD_ALIGN_BIT = 6;
  localparam int VICD_TD_RATIO_LSB = 0;

  // Cropping register fields
  localparam int VICD_CR_VD_LSB = 6;
  localparam int VICD_CR_VA_LSB = 4;
  localparam int VICD_CR_HD_LSB = 2;
  localparam int VICD_CR_HA_LSB = 0;

  // Video standard codes
  typedef enum logic [2:0] {
    VICD_STD_AUTO = 3'h0,
    VICD_STD_NTSC_M = 3'h1,
    VICD_STD_NTSC_NOPED = 3'h2,
    VICD_STD_PAL_BDGHI = 3'h3,
    VICD_STD_PAL_M = 3'h4,
    VICD_STD_PAL_N = 3'h5,
    VICD_STD_SECAM = 3'h6,
    VICD_STD_RSVD = 3'h7
  } vicd_std_e;

  // Decimation periods and line count filter length
  localparam logic [6:0] VICD_PERIOD_525 = 7'h3c;
  localparam logic [6:0] VICD_PERIOD_625 = 7'h32;
  localparam logic [4:0] VICD_LC_LAST = 5'h1f;

endpackage

// ==== vicd_field_bank.sv ====
// One field's copy of the cropping and lower-byte offset registers.
// Assumes write strobes are decoded by the parent, one cycle each.
`timescale 1ns/1ns
module vicd_field_bank
  import vicd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Write strobes and data
  input wire logic wr_upper_bits_reg_a_low,
  input wire logic wr_upper_bits_reg_a_vd,
  input wire logic wr_vdl,
  input wire logic wr_val,
  input wire logic wr_hdl,
  input wire logic [7:0] wdata,
  // Stored values
  output logic [7:0] upper_bits_reg_a_q,
  output logic [7:0] vdl_q,
  output logic [7:0] val_q,
  output logic [7:0] hdl_q
);

  logic [7:0] upper_bits_reg_a_d;
  logic [7:0] vdl_d;
  logic [7:0] val_d;
  logic [7:0] hdl_d;

  // Top bits of the vertical delay arrive through the other field's address
  always_comb begin
    upper_bits_reg_a_d = upper_bits_reg_a_q;
    vdl_d = vdl_q;
    val_d = val_q;
    hdl_d = hdl_q;
    if (wr_upper_bits_reg_a_low) begin
      upper_bits_reg_a_d[5:0] = wdata[5:0];
    end
    if (wr_upper_bits_reg_a_vd) begin
      upper_bits_reg_a_d[7:6] = wdata[7:6];
    end
    if (wr_vdl) begin
      vdl_d = wdata;
    end
    if (wr_val) begin
      val_d = wdata;
    end
    if (wr_hdl) begin
      hdl_d = wdata;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      upper_bits_reg_a_q <= VICD_RST_UPPER_BITS_REG_A;
      vdl_q <= VICD_RST_VDL;
      val_q <= VICD_RST_VAL;
      hdl_q <= VICD_RST_HDL;
    end else begin
      upper_bits_reg_a_q <= upper_bits_reg_a_d;
      vdl_q <= vdl_d;
      val_q <= val_d;
      hdl_q <= hdl_d;
    end
  end

endmodule // vicd_field_bank

// ==== vicd_line_filter.sv ====
// Line count status filter: follows the per-field line count only after
// thirty-two consecutive fields agree. Inputs are on the clk_sys domain.
`timescale 1ns/1ns
module vicd_line_filter
  import vicd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Per-field measurement
  input wire logic field_start,
  input wire logic field_625,
  // Filtered status
  output logic line_count_status
);

  logic status_q;
  logic status_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;

  // Count disagreeing fields; any agreeing field restarts the run
  always_comb begin
    status_d = status_q;
    cnt_d = cnt_q;
    if (field_start) begin
      if (field_625 == status_q) begin
        cnt_d = 5'h0;
      end else if (cnt_q == VICD_LC_LAST) begin
        status_d = field_625;
        cnt_d = 5'h0;
      end else begin
        cnt_d = cnt_q + 5'h1;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_q <= 1'b0;
      cnt_q <= 5'h0;
    end else begin
      status_q <= status_d;
      cnt_q <= cnt_d;
    end
  end

  assign line_count_status = status_q;

endmodule // vicd_line_filter

// ==== vicd_regs.sv ====
// Video input format, temporal decimation and per-field upper_bits_reg_a registers.
// Assumes a decoded register port on clk_sys and field timing pulses from
// the decoder on the same clock.
`timescale 1ns/1ns
module vicd_regs
  import vicd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // Field timing from the decoder
  input wire logic field_start,
  input wire logic field_is_even,
  input wire logic field_625,
  // Input routing and standard
  output logic [1:0] source_index,
  output logic source_valid,
  output logic crystal_one_sel,
  output logic crystal_auto,
  output logic [2:0] video_standard,
  output logic line_count_status,
  // Decimation
  output logic field_drop,
  // Active field geometry
  output logic [9:0] vertical_start_offset,
  output logic [9:0] vertical_scaled_lines,
  output logic [9:0] horizontal_start_offset,
  output logic [1:0] horiz_active_top_bits
);

  // Register storage
  logic [7:0] ifmt_q;
  logic [7:0] ifmt_d;
  logic [7:0] temporal_decimation_ctrl_q;
  logic [7:0] temporal_decimation_ctrl_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // Per-field bank outputs
  logic [7:0] even_upper_bits_reg_a_upper_bits;
  logic [7:0] e_vdl;
  logic [7:0] e_val;
  logic [7:0] e_hdl;
  logic [7:0] odd_upper_bits_reg_a_upper_bits;
  logic [7:0] o_vdl;
  logic [7:0] o_val;
  logic [7:0] o_hdl;

  // Decoded strobes
  logic wr_lane0;
  logic hit_even_upper_bits_reg_a_upper_bits;
  logic hit_odd_upper_bits_reg_a_upper_bits;
  logic lc_status;

  // Output registers
  logic [1:0] src_idx_q;
  logic [1:0] src_idx_d;
  logic src_ok_q;
  logic src_ok_d;
  logic xt_one_q;
  logic xt_one_d;
  logic xt_auto_q;
  logic xt_auto_d;
  logic [2:0] std_q;
  logic [2:0] std_d;
  logic lcs_q;
  logic [9:0] vso_q;
  logic [9:0] vso_d;
  logic [9:0] vsl_q;
  logic [9:0] vsl_d;
  logic [9:0] hso_q;
  logic [9:0] hso_d;
  logic [1:0] hat_q;
  logic [1:0] hat_d;

  // Decimation state
  logic drop_q;
  logic drop_d;
  logic synced_q;
  logic synced_d;
  logic [5:0] unit_cnt_q;
  logic [5:0] unit_cnt_d;
  logic [6:0] acc_q;
  logic [6:0] acc_d;

  // Only lane 0 carries data, so a write without it is ignored
  assign wr_lane0 = reg_wr & reg_be[0];
  assign hit_even_upper_bits_reg_a_upper_bits = wr_lane0 & (reg_addr == VICD_OFF_EVEN_UPPER_BITS_REG_A_UPPER_BITS);
  assign hit_odd_upper_bits_reg_a_upper_bits = wr_lane0 & (reg_addr == VICD_OFF_ODD_UPPER_BITS_REG_A_UPPER_BITS);

  // Even field copy; its vertical delay top bits come via the odd address
  vicd_field_bank u_even_bank (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_upper_bits_reg_a_low(hit_even_upper_bits_reg_a_upper_bits),
    .wr_upper_bits_reg_a_vd(hit_odd_upper_bits_reg_a_upper_bits),
    .wr_vdl(wr_lane0 & (reg_addr == VICD_OFF_E_VDL)),
    .wr_val(wr_lane0 & (reg_addr == VICD_OFF_E_VAL)),
    .wr_hdl(wr_lane0 & (reg_addr == VICD_OFF_E_HDL)),
    .wdata(reg_wdata[7:0]),
    .upper_bits_reg_a_q(even_upper_bits_reg_a_upper_bits),
    .vdl_q(e_vdl),
    .val_q(e_val),
    .hdl_q(e_hdl)
  );

  // Odd field copy; its vertical delay top bits come via the even address
  vicd_field_bank u_odd_bank (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_upper_bits_reg_a_low(hit_odd_upper_bits_reg_a_upper_bits),
    .wr_upper_bits_reg_a_vd(hit_even_upper_bits_reg_a_upper_bits),
    .wr_vdl(wr_lane0 & (reg_addr == VICD_OFF_O_VDL)),
    .wr_val(wr_lane0 & (reg_addr == VICD_OFF_O_VAL)),
    .wr_hdl(wr_lane0 & (reg_addr == VICD_OFF_O_HDL)),
    .wdata(reg_wdata[7:0]),
    .upper_bits_reg_a_q(odd_upper_bits_reg_a_upper_bits),
    .vdl_q(o_vdl),
    .val_q(o_val),
    .hdl_q(o_hdl)
  );

  // Line count status follows only a stable run of fields
  vicd_line_filter u_line_filter (
    .clk_sys(clk_sys),
    .srst(srst),
    .field_start(field_start),
    .field_625(field_625),
    .line_count_status(lc_status)
  );

  // Register writes and read mux; reads mirror the write address mapping
  always_comb begin
    ifmt_d = ifmt_q;
    temporal_decimation_ctrl_d = temporal_decimation_ctrl_q;
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    if (wr_lane0 && reg_addr == VICD_OFF_IFMT) begin
      ifmt_d = reg_wdata[7:0];
    end
    if (wr_lane0 && reg_addr == VICD_OFF_TEMPORAL_DECIMATION_CTRL) begin
      temporal_decimation_ctrl_d = reg_wdata[7:0];
    end
    if (reg_rd) begin
      rdata_d = 32'h0000_0000;
      case (reg_addr)
        VICD_OFF_IFMT: rdata_d[7:0] = ifmt_q;
        VICD_OFF_TEMPORAL_DECIMATION_CTRL: rdata_d[7:0] = temporal_decimation_ctrl_q;
        VICD_OFF_EVEN_UPPER_BITS_REG_A_UPPER_BITS: rdata_d[7:0] = {odd_upper_bits_reg_a_upper_bits[7:6], even_upper_bits_reg_a_upper_bits[5:0]};
        VICD_OFF_E_VDL: rdata_d[7:0] = e_vdl;
        VICD_OFF_E_VAL: rdata_d[7:0] = e_val;
        VICD_OFF_E_HDL: rdata_d[7:0] = e_hdl;
        VICD_OFF_ODD_UPPER_BITS_REG_A_UPPER_BITS: rdata_d[7:0] = {even_upper_bits_reg_a_upper_bits[7:6], odd_upper_bits_reg_a_upper_bits[5:0]};
        VICD_OFF_O_VDL: rdata_d[7:0] = o_vdl;
        VICD_OFF_O_VAL: rdata_d[7:0] = o_val;
        VICD_OFF_O_HDL: rdata_d[7:0] = o_hdl;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register port state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ifmt_q <= VICD_RST_IFMT;
      temporal_decimation_ctrl_q <= VICD_RST_TEMPORAL_DECIMATION_CTRL;
      rdata_q <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      ifmt_q <= ifmt_d;
      temporal_decimation_ctrl_q <= temporal_decimation_ctrl_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Source, crystal and standard decode; reserved codes hold the last route
  always_comb begin
    src_idx_d = src_idx_q;
    src_ok_d = 1'b1;
    case (ifmt_q[VICD_IF_SRC_LSB +: 2])
      2'h1: src_idx_d = 2'h2;
      2'h2: src_idx_d = 2'h0;
      2'h3: src_idx_d = 2'h1;
      default: src_ok_d = 1'b0;
    endcase
    xt_auto_d = 1'b0;
    xt_one_d = xt_one_q;
    case (ifmt_q[VICD_IF_XT_LSB +: 2])
      2'h1: xt_one_d = 1'b0;
      2'h2: xt_one_d = 1'b1;
      2'h3: begin
        xt_auto_d = 1'b1;
        xt_one_d = lc_status;
      end
      default: xt_one_d = xt_one_q;
    endcase
    // Auto picks the common standard of each line count
    case (ifmt_q[VICD_IF_STD_LSB +: 3])
      VICD_STD_AUTO: std_d = lc_status ? VICD_STD_PAL_BDGHI : VICD_STD_NTSC_M;
      VICD_STD_RSVD: std_d = std_q;
      default: std_d = ifmt_q[VICD_IF_STD_LSB +: 3];
    endcase
  end

  // Active field values switch with the field indication
  always_comb begin
    // Each bank already holds its own field's top bits; the address swap
    // is done at the write strobes, so no second swap belongs here.
    if (field_is_even) begin
      vso_d = {even_upper_bits_reg_a_upper_bits[VICD_CR_VD_LSB +: 2], e_vdl};
      vsl_d = {even_upper_bits_reg_a_upper_bits[VICD_CR_VA_LSB +: 2], e_val};
      hso_d = {even_upper_bits_reg_a_upper_bits[VICD_CR_HD_LSB +: 2], e_hdl};
      hat_d = even_upper_bits_reg_a_upper_bits[VICD_CR_HA_LSB +: 2];
    end else begin
      vso_d = {odd_upper_bits_reg_a_upper_bits[VICD_CR_VD_LSB +: 2], o_vdl};
      vsl_d = {odd_upper_bits_reg_a_upper_bits[VICD_CR_VA_LSB +: 2], o_val};
      hso_d = {odd_upper_bits_reg_a_upper_bits[VICD_CR_HD_LSB +: 2], o_hdl};
      hat_d = odd_upper_bits_reg_a_upper_bits[VICD_CR_HA_LSB +: 2];
    end
  end

  // Decoded output registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      src_idx_q <= 2'h0;
      src_ok_q <= 1'b0;
      xt_one_q <= 1'b0;
      xt_auto_q <= 1'b0;
      std_q <= VICD_STD_NTSC_M;
      lcs_q <= 1'b0;
      vso_q <= 10'h000;
      vsl_q <= 10'h000;
      hso_q <= 10'h000;
      hat_q <= 2'h0;
    end else begin
      src_idx_q <= src_idx_d;
      src_ok_q <= src_ok_d;
      xt_one_q <= xt_one_d;
      xt_auto_q <= xt_auto_d;
      std_q <= std_d;
      lcs_q <= lc_status;
      vso_q <= vso_d;
      vsl_q <= vsl_d;
      hso_q <= hso_d;
      hat_q <= hat_d;
    end
  end

  // Decimation: an accumulator spreads the drops over the period, and
  // priming it at period start makes the first aligned unit a drop.
  logic [6:0] period;
  logic [6:0] ratio;
  logic [6:0] sum;
  logic first_of_unit;
  logic aligned;
  always_comb begin
    period = lc_status ? VICD_PERIOD_625 : VICD_PERIOD_525;
    ratio = {1'b0, temporal_decimation_ctrl_q[VICD_TD_RATIO_LSB +: 6]};
    aligned = (field_is_even == temporal_decimation_ctrl_q[VICD_TD_ALIGN_BIT]);
    // A frame starts on the aligned parity; fields are units of their own
    first_of_unit = temporal_decimation_ctrl_q[VICD_TD_UNIT_BIT] | aligned;
    sum = 7'h00;
    drop_d = drop_q;
    synced_d = synced_q;
    unit_cnt_d = unit_cnt_q;
    acc_d = acc_q;
    if (ratio == 7'h00) begin
      drop_d = 1'b0;
      synced_d = 1'b0;
      unit_cnt_d = 6'h00;
    end else if (field_start && first_of_unit) begin
      if (!synced_q && !aligned) begin
        drop_d = 1'b0;
      end else begin
        if (unit_cnt_q == 6'h00) begin
          sum = period;
        end else begin
          sum = acc_q + ratio;
        end
        drop_d = (sum >= period) || (ratio >= period);
        acc_d = (sum >= period) ? sum - period : sum;
        synced_d = 1'b1;
        if ({1'b0, unit_cnt_q} == period - 7'h01) begin
          unit_cnt_d = 6'h00;
        end else begin
          unit_cnt_d = unit_cnt_q + 6'h01;
        end
      end
    end
  end

  // Decimation state registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      drop_q <= 1'b0;
      synced_q <= 1'b0;
      unit_cnt_q <= 6'h00;
      acc_q <= 7'h00;
    end else begin
      drop_q <= drop_d;
      synced_q <= synced_d;
      unit_cnt_q <= unit_cnt_d;
      acc_q <= acc_d;
    end
  end

  // Output drive, all straight from flip-flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign source_index = src_idx_q;
  assign source_valid = src_ok_q;
  assign crystal_one_sel = xt_one_q;
  assign crystal_auto = xt_auto_q;
  assign video_standard = std_q;
  assign line_count_status = lcs_q;
  assign field_drop = drop_q;
  assign vertical_start_offset = vso_q;
  assign vertical_scaled_lines = vsl_q;
  assign horizontal_start_offset = hso_q;
  assign horiz_active_top_bits = hat_q;

endmodule // vicd_regs

// ==== vicd_regs_checker.sv ====
// Concurrent checks on the ports of the video upper_bits_reg_a and decimation registers.
// Assumes every port sits on clk_sys with the synchronous srst.
`timescale 1ns/1ns
module vicd_regs_checker
  import vicd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  // Field timing
  input wire logic field_start,
  input wire logic field_is_even,
  input wire logic field_625,
  // Decoded outputs
  input wire logic [1:0] source_index,
  input wire logic source_valid,
  input wire logic crystal_one_sel,
  input wire logic crystal_auto,
  input wire logic [2:0] video_standard,
  input wire logic line_count_status,
  input wire logic field_drop,
  input wire logic [9:0] vertical_start_offset,
  input wire logic [9:0] vertical_scaled_lines,
  input wire logic [9:0] horizontal_start_offset,
  input wire logic [1:0] horiz_active_top_bits
);
  logic ifmt_wr;
  logic [1:0] zf_q;
  logic [1:0] zf_d;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  assign ifmt_wr = reg_wr && reg_be[0] && reg_addr == VICD_OFF_IFMT;

  // Fields since the ratio went to zero; a held frame decision may linger
  always_comb begin
    zf_d = zf_q;
    if (reg_wr && reg_be[0] && reg_addr == VICD_OFF_TEMPORAL_DECIMATION_CTRL) begin
      zf_d = (reg_wdata[5:0] == 6'h00) ? 2'h0 : 2'h3;
    end else if (field_start && zf_q < 2'h2) begin
      zf_d = zf_q + 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    zf_q <= srst ? 2'h2 : zf_d;
  end

  sequence s_quiet_field;
    field_start && zf_q == 2'h2 ##1 zf_q == 2'h2;
  endsequence

  property p_rvalid; reg_rd |=> reg_rvalid; endproperty
  property p_upper; reg_rvalid |-> reg_rdata[31:8] == 24'h00_0000; endproperty
  property p_rst_decode;
    $fell(srst) |-> ##2 (source_index == 2'h0 && source_valid &&
      crystal_auto && video_standard == 3'h1);
  endproperty
  property p_src;
    ifmt_wr && reg_wdata[6:5] != 2'h0 |-> ##2 (source_valid &&
      source_index == (($past(reg_wdata[6:5], 2) == 2'h1) ? 2'h2 :
      $past(reg_wdata[6:5], 2) - 2'h2));
  endproperty
  property p_xtal;
    ifmt_wr && reg_wdata[4:3] != 2'h0 |-> ##2
      (crystal_auto == (&$past(reg_wdata[4:3], 2))) &&
      (crystal_auto || crystal_one_sel == $past(reg_wdata[4], 2));
  endproperty
  property p_std;
    ifmt_wr && reg_wdata[2:0] != 3'h0 && reg_wdata[2:0] != 3'h7 |-> ##2
      video_standard == $past(reg_wdata[2:0], 2);
  endproperty
  property p_auto;
    ifmt_wr && reg_wdata[2:0] == 3'h0 |-> ##2
      video_standard == (line_count_status ? 3'h3 : 3'h1);
  endproperty
  property p_lcs; $changed(line_count_status) |-> $past(field_start, 2);
  endproperty
  property p_no_drop; s_quiet_field |=> !field_drop; endproperty

  a_rvalid: assert property (p_rvalid)
    else $error("read strobe not answered");
  a_upper: assert property (p_upper)
    else $error("upper read lanes not zero");
  a_rst_decode: assert property (p_rst_decode)
    else $error("decode after reset wrong");
  a_src: assert property (p_src)
    else $error("source routing wrong");
  a_xtal: assert property (p_xtal)
    else $error("crystal decode wrong");
  a_std: assert property (p_std)
    else $error("standard decode wrong");
  a_auto: assert property (p_auto)
    else $error("automatic standard wrong");
  a_lcs: assert property (p_lcs)
    else $error("line count status moved without a field");
  a_no_drop: assert property (p_no_drop)
    else $error("field dropped at zero ratio");
endmodule // vicd_regs_checker

bind vicd_regs vicd_regs_checker u_chk (
  .clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .field_start(field_start), .field_is_even(field_is_even),
  .field_625(field_625), .source_index(source_index),
  .source_valid(source_valid), .crystal_one_sel(crystal_one_sel),
  .crystal_auto(crystal_auto), .video_standard(video_standard),
  .line_count_status(line_count_status), .field_drop(field_drop),
  .vertical_start_offset(vertical_start_offset),
  .vertical_scaled_lines(vertical_scaled_lines),
  .horizontal_start_offset(horizontal_start_offset),
  .horiz_active_top_bits(horiz_active_top_bits)
);

// ==== vicd_regs_bench.sv ====
// Self-checking bench for the video upper_bits_reg_a and decimation registers.
// Assumes the bench drives register strobes and field timing itself.
`timescale 1ns/1ns
module vicd_regs_bench
  import vicd_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [3:0] reg_be = 4'hf;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic field_start = 1'b0;
  logic field_is_even = 1'b1;
  logic field_625 = 1'b0;
  logic [31:0] reg_rdata;
  logic reg_rvalid, source_valid, crystal_one_sel, crystal_auto;
  logic line_count_status, field_drop;
  logic [1:0] source_index, horiz_active_top_bits;
  logic [2:0] video_standard;
  logic [9:0] vertical_start_offset, vertical_scaled_lines;
  logic [9:0] horizontal_start_offset;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  vicd_regs uut (
    .clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .field_start(field_start), .field_is_even(field_is_even),
    .field_625(field_625), .source_index(source_index),
    .source_valid(source_valid), .crystal_one_sel(crystal_one_sel),
    .crystal_auto(crystal_auto), .video_standard(video_standard),
    .line_count_status(line_count_status), .field_drop(field_drop),
    .vertical_start_offset(vertical_start_offset),
    .vertical_scaled_lines(vertical_scaled_lines),
    .horizontal_start_offset(horizontal_start_offset),
    .horiz_active_top_bits(horiz_active_top_bits)
  );

  // 25 MHz clock and a cycle ceiling well above the planned run
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] be = 4'h1);
    tick(1);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_be = be;
    reg_wdata = {24'hA5_A5A5, d};
    tick(1);
    reg_wr = 1'b0;
  endtask

  // All lanes enabled so the upper bytes must come back zero
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    tick(1);
    reg_rd = 1'b1;
    reg_addr = a;
    reg_be = 4'hf;
    tick(1);
    reg_rd = 1'b0;
    chk("rvalid", 1, reg_rvalid);
    chk("rdata", {24'h00_0000, e}, reg_rdata);
  endtask

  // One short field; the drop decision is sampled mid-field
  task automatic field(input logic ev, input logic l625, output logic drop);
    tick(1);
    field_start = 1'b1;
    field_is_even = ev;
    field_625 = l625;
    tick(1);
    field_start = 1'b0;
    tick(3);
    drop = field_drop;
  endtask

  task automatic geom(input logic [9:0] vs, vl, hs, input logic [1:0] ha);
    tick(2);
    chk("vstart", vs, vertical_start_offset);
    chk("vlines", vl, vertical_scaled_lines);
    chk("hstart", hs, horizontal_start_offset);
    chk("hatop", ha, horiz_active_top_bits);
  endtask

  task automatic t_reset;
    logic [11:0] offs [10] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
      12'h018, 12'h08c, 12'h090, 12'h094, 12'h098};
    logic [7:0] vals [10] = '{8'h58, 8'h00, 8'h12, 8'h16, 8'he0, 8'h78,
      8'h12, 8'h16, 8'he0, 8'h78};
    for (int i = 0; i < 10; i++) begin
      rd(offs[i], vals[i]);
    end
    rd(12'h0fc, 8'h00);
    wr(VICD_OFF_IFMT, 8'h21, 4'he);
    rd(VICD_OFF_IFMT, 8'h58);
    geom(10'h016, 10'h1e0, 10'h078, 2'h2);
  endtask

  task automatic t_ifmt;
    logic [1:0] s;
    logic [7:0] v;
    for (int i = 1; i <= 7; i++) begin
      s = 2'(i % 3 + 1);
      v = {1'b0, s, s, 3'(i)};
      wr(VICD_OFF_IFMT, v);
      rd(VICD_OFF_IFMT, v);
      tick(1);
      chk("src", (s == 2'h1) ? 2'h2 : s - 2'h2, source_index);
      chk("srcok", 1, source_valid);
      chk("xauto", s == 2'h3, crystal_auto);
      if (s != 2'h3) chk("xone", s == 2'h2, crystal_one_sel);
      chk("std", (i == 7) ? 3'h6 : 3'(i), video_standard);
    end
    // A reserved selector code clears source_valid; reserved crystal code holds crystal_one_sel, clears crystal_auto; reserved standard holds
    wr(VICD_OFF_IFMT, 8'h07);
    tick(2);
    chk("srcok0", 0, source_valid);
    chk("xhold", 1, crystal_one_sel);
    chk("xauto0", 0, crystal_auto);
    chk("stdhold", 3'h6, video_standard);
    wr(VICD_OFF_IFMT, 8'h58);
    tick(2);
    chk("autostd", 3'h1, video_standard);
  endtask

  task automatic t_upper_bits_reg_a;
    wr(VICD_OFF_EVEN_UPPER_BITS_REG_A_UPPER_BITS, 8'hc5);
    wr(VICD_OFF_ODD_UPPER_BITS_REG_A_UPPER_BITS, 8'h40);
    wr(VICD_OFF_E_VDL, 8'h33);
    rd(VICD_OFF_EVEN_UPPER_BITS_REG_A_UPPER_BITS, 8'hc5);
    rd(VICD_OFF_ODD_UPPER_BITS_REG_A_UPPER_BITS, 8'h40);
    field_is_even = 1'b1;
    geom(10'h133, 10'h0e0, 10'h178, 2'h1);
    field_is_even = 1'b0;
    geom(10'h316, 10'h0e0, 10'h078, 2'h0);
  endtask

  // Runs fields from an even one; counts drops, notes first dropped parity.
  // A zero ratio first, so the decimation restarts on the aligned parity.
  task automatic run(input logic [7:0] td, input int n, input int e_cnt,
                     input logic e_par);
    int cnt;
    logic d;
    logic par;
    cnt = 0;
    par = 1'bx;
    wr(VICD_OFF_TEMPORAL_DECIMATION_CTRL, 8'h00);
    wr(VICD_OFF_TEMPORAL_DECIMATION_CTRL, td);
    for (int i = 0; i < n; i++) begin
      field(i % 2 == 0, line_count_status, d);
      if (d === 1'b1 && cnt == 0) par = (i % 2 == 0);
      if (d === 1'b1) cnt++;
    end
    chk("drops", e_cnt, cnt);
    if (e_cnt > 0) chk("firstpar", e_par, par);
  endtask

  task automatic t_dec;
    run(8'h81, 120, 2, 1'b0);
    run(8'hc1, 120, 2, 1'b1);
    run(8'h01, 120, 2, 1'b0);
    run(8'h00, 8, 0, 1'b0);
  endtask

  task automatic t_auto;
    logic d;
    for (int i = 0; i < 31; i++) field(i % 2 == 0, 1'b1, d);
    chk("lcs31", 0, line_count_status);
    field(1'b0, 1'b1, d);
    tick(2);
    chk("lcs32", 1, line_count_status);
    chk("autopal", 3'h3, video_standard);
    chk("autoxt", 1, crystal_one_sel);
    // A 50-unit period drops three fields in 110, a 60-unit one only two
    run(8'h81, 110, 3, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    tick(3);
    t_reset();
    t_ifmt();
    t_upper_bits_reg_a();
    t_dec();
    t_auto();
    finish_test();
  end
endmodule // vicd_regs_bench
